//--- fdrf_pkg.sv
/*
 * fdrf_pkg: register offsets, field positions, reset values, step table and
 * slot timing for the fan duty ramp and floor block.
 * assumes: an 8-bit register port with byte-wide offsets.
 */
`default_nettype none

package fdrf_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_ACOUSTIC_RAMP_CONTROL = 8'h62;
    localparam logic [7:0] ADDR_FAN1_FLOOR_DUTY       = 8'h64;
    localparam logic [7:0] ADDR_FAN2_FLOOR_DUTY       = 8'h65;
    localparam logic [7:0] ADDR_FAN3_FLOOR_DUTY       = 8'h66;
    // below-start choice bits and mode, kept at a register of their own
    localparam logic [7:0] ADDR_FAN_MODE_CONTROL      = 8'h63;

    // ------------------------------------------------------------------
    // fields
    // ------------------------------------------------------------------
    localparam int STEP3_LSB  = 0;
    localparam int SMOOTH3_BIT = 3;
    localparam int STEP2_LSB  = 4;
    localparam int SMOOTH2_BIT = 7;
    localparam int AUTO_MODE_BIT = 0;
    localparam int KEEP_FLOOR1_BIT = 5;
    localparam int KEEP_FLOOR2_BIT = 6;
    localparam int KEEP_FLOOR3_BIT = 7;

    // ------------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ACOUSTIC_RAMP_CONTROL = 8'h00;
    localparam logic [7:0] RST_FLOOR_DUTY            = 8'h80;
    localparam logic [7:0] RST_FAN_MODE_CONTROL      = 8'h00;

    // ------------------------------------------------------------------
    // slot timing: 1 step at code 000 moves 33% to 100% (171 counts) in 35 s
    // ------------------------------------------------------------------
    localparam int  CLK_MHZ        = 250;
    localparam int  SLOT_US        = 204_678;
    localparam longint SLOT_CYCLES = longint'(SLOT_US) * longint'(CLK_MHZ);

    typedef enum logic [2:0] {
        FDRF_IDLE = 3'b001,
        FDRF_RAMP = 3'b010,
        FDRF_HOLD = 3'b100
    } fdrf_state_t;

    function automatic logic [7:0] step_of(input logic [2:0] code);
        case (code)
            3'h0: step_of = 8'h01;
            3'h1: step_of = 8'h02;
            3'h2: step_of = 8'h03;
            3'h3: step_of = 8'h05;
            3'h4: step_of = 8'h08;
            3'h5: step_of = 8'h0c;
            3'h6: step_of = 8'h18;
            default: step_of = 8'h30;
        endcase
    endfunction

endpackage

`default_nettype wire

//--- fdrf_ramp.sv
/*
 * fdrf_ramp: one drive's duty ramp toward a target.
 * assumes: slot_tick is a one-cycle pulse; target stable or slowly changing.
 */
`default_nettype none

module fdrf_ramp (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       slot_tick,
    input  wire logic       smooth_en,
    input  wire logic [2:0] step_sel,
    input  wire logic [7:0] target,
    output logic      [7:0] duty
);

    logic [7:0] duty_reg;
    logic [7:0] duty_next;
    logic [7:0] step;
    logic [8:0] up_sum;
    logic [8:0] dn_dif;
    fdrf_pkg::fdrf_state_t state_reg;

    assign step   = fdrf_pkg::step_of(step_sel);
    assign up_sum = {1'b0, duty_reg} + {1'b0, step};
    assign dn_dif = {1'b0, duty_reg} - {1'b0, step};

    always_comb begin
        duty_next = duty_reg;
        if (!smooth_en) begin
            duty_next = target;
        end else if (slot_tick) begin
            // clamp at target: no overshoot, no wrap
            if (duty_reg < target) begin
                duty_next = (up_sum[8] || up_sum[7:0] > target) ? target : up_sum[7:0];
            end else if (duty_reg > target) begin
                duty_next = (dn_dif[8] || dn_dif[7:0] < target) ? target : dn_dif[7:0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            duty_reg <= 8'h00;
        end else begin
            duty_reg <= duty_next;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= fdrf_pkg::FDRF_IDLE;
        end else begin
            case (state_reg)
                fdrf_pkg::FDRF_IDLE: state_reg <= (duty_next != target) ? fdrf_pkg::FDRF_RAMP : fdrf_pkg::FDRF_HOLD;
                fdrf_pkg::FDRF_RAMP: state_reg <= (duty_next == target) ? fdrf_pkg::FDRF_HOLD : fdrf_pkg::FDRF_RAMP;
                fdrf_pkg::FDRF_HOLD: state_reg <= (duty_next != target) ? fdrf_pkg::FDRF_RAMP : fdrf_pkg::FDRF_HOLD;
                default:             state_reg <= fdrf_pkg::FDRF_IDLE;
            endcase
        end
    end

    assign duty = duty_reg;

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_step_bound;
        @(posedge clk) disable iff (rst)
        (smooth_en && $past(smooth_en)) |->
            ((duty_reg >= $past(duty_reg) ? duty_reg - $past(duty_reg) : $past(duty_reg) - duty_reg)
             <= fdrf_pkg::step_of($past(step_sel)));
    endproperty
    a_step_bound: assert property (p_step_bound) else $error("ramp step too large");

    property p_slot_only;
        @(posedge clk) disable iff (rst)
        (smooth_en && !slot_tick) |=> (duty_reg == $past(duty_reg));
    endproperty
    a_slot_only: assert property (p_slot_only) else $error("duty moved outside a slot");

    property p_direct;
        @(posedge clk) disable iff (rst)
        !smooth_en |=> (duty_reg == $past(target));
    endproperty
    a_direct: assert property (p_direct) else $error("duty not taken directly");

    property p_no_overshoot;
        @(posedge clk) disable iff (rst)
        (smooth_en && $past(duty_reg) <= $past(target) && $past(smooth_en)) |-> (duty_reg <= $past(target));
    endproperty
    a_no_overshoot: assert property (p_no_overshoot) else $error("ramp overshoot");

endmodule

`default_nettype wire

//--- fdrf_top.sv
/*
 * fdrf_top: fan duty ramp and floor block with its registers.
 * assumes: register port master on CORE_CLK, one-cycle strobes, never both;
 * target duties come from the fan control loop on the same clock.
 */
`default_nettype none

module fdrf_top #(
    parameter longint SLOT_CYCLES = fdrf_pkg::SLOT_CYCLES
) (
    input  wire logic       CORE_CLK,
    input  wire logic       RST,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic      [7:0] REG_RDATA,
    input  wire logic [7:0] CALC_DUTY_1,
    input  wire logic [7:0] CALC_DUTY_2,
    input  wire logic [7:0] CALC_DUTY_3,
    input  wire logic [2:0] BELOW_START,
    output logic      [7:0] FAN_DRIVE_1,
    output logic      [7:0] FAN_DRIVE_2,
    output logic      [7:0] FAN_DRIVE_3
);

    initial begin
        if (SLOT_CYCLES < 2 || SLOT_CYCLES > 64'd4294967295) begin
            $error("SLOT_CYCLES out of range");
        end
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    logic [7:0]  ramp_ctrl_reg;
    logic [7:0]  mode_ctrl_reg;
    logic [7:0]  floor_duty_reg [3];
    logic [7:0]  rdata_reg;
    logic        auto_mode;
    logic [2:0]  ramp_step_sel_drive3;
    logic [2:0]  ramp_step_sel_drive2;
    logic        smooth_enable_drive3;
    logic        smooth_enable_drive2;
    logic [2:0]  below_start_keep_floor;

    assign ramp_step_sel_drive3   = ramp_ctrl_reg[fdrf_pkg::STEP3_LSB +: 3];
    assign smooth_enable_drive3   = ramp_ctrl_reg[fdrf_pkg::SMOOTH3_BIT];
    assign ramp_step_sel_drive2   = ramp_ctrl_reg[fdrf_pkg::STEP2_LSB +: 3];
    assign smooth_enable_drive2   = ramp_ctrl_reg[fdrf_pkg::SMOOTH2_BIT];
    assign auto_mode              = mode_ctrl_reg[fdrf_pkg::AUTO_MODE_BIT];
    assign below_start_keep_floor = {mode_ctrl_reg[fdrf_pkg::KEEP_FLOOR3_BIT],
                                     mode_ctrl_reg[fdrf_pkg::KEEP_FLOOR2_BIT],
                                     mode_ctrl_reg[fdrf_pkg::KEEP_FLOOR1_BIT]};

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            ramp_ctrl_reg <= fdrf_pkg::RST_ACOUSTIC_RAMP_CONTROL;
        end else if (REG_WR && REG_ADDR == fdrf_pkg::ADDR_ACOUSTIC_RAMP_CONTROL) begin
            ramp_ctrl_reg <= REG_WDATA;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            mode_ctrl_reg <= fdrf_pkg::RST_FAN_MODE_CONTROL;
        end else if (REG_WR && REG_ADDR == fdrf_pkg::ADDR_FAN_MODE_CONTROL) begin
            mode_ctrl_reg <= REG_WDATA & 8'he1;
        end
    end

    // floor duties, linear 8-bit scale
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            for (int i = 0; i < 3; i++) begin
                floor_duty_reg[i] <= fdrf_pkg::RST_FLOOR_DUTY;
            end
        end else if (REG_WR && !auto_mode) begin
            for (int i = 0; i < 3; i++) begin
                if (REG_ADDR == fdrf_pkg::ADDR_FAN1_FLOOR_DUTY + 8'(i)) begin
                    floor_duty_reg[i] <= REG_WDATA;
                end
            end
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            rdata_reg <= 8'h00;
        end else if (REG_RD) begin
            case (REG_ADDR)
                fdrf_pkg::ADDR_ACOUSTIC_RAMP_CONTROL: rdata_reg <= ramp_ctrl_reg;
                fdrf_pkg::ADDR_FAN_MODE_CONTROL:      rdata_reg <= mode_ctrl_reg;
                fdrf_pkg::ADDR_FAN1_FLOOR_DUTY:       rdata_reg <= floor_duty_reg[0];
                fdrf_pkg::ADDR_FAN2_FLOOR_DUTY:       rdata_reg <= floor_duty_reg[1];
                fdrf_pkg::ADDR_FAN3_FLOOR_DUTY:       rdata_reg <= floor_duty_reg[2];
                default:                              rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    assign REG_RDATA = rdata_reg;

    // ------------------------------------------------------------------
    // time slot
    // ------------------------------------------------------------------
    logic [31:0] slot_cnt_reg;
    logic        slot_tick;

    // slot length sets 35 s per 171 counts at step 1
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            slot_cnt_reg <= 32'h0000_0000;
        end else if (slot_cnt_reg == 32'(SLOT_CYCLES - 1)) begin
            slot_cnt_reg <= 32'h0000_0000;
        end else begin
            slot_cnt_reg <= slot_cnt_reg + 32'h0000_0001;
        end
    end

    assign slot_tick = (slot_cnt_reg == 32'(SLOT_CYCLES - 1));

    // ------------------------------------------------------------------
    // targets with floor
    // ------------------------------------------------------------------
    logic [7:0] target [3];
    logic [7:0] calc   [3];

    assign calc[0] = CALC_DUTY_1;
    assign calc[1] = CALC_DUTY_2;
    assign calc[2] = CALC_DUTY_3;

    always_comb begin
        for (int i = 0; i < 3; i++) begin
            target[i] = calc[i];
            if (auto_mode) begin
                if (BELOW_START[i]) begin
                    target[i] = below_start_keep_floor[i] ? floor_duty_reg[i] : 8'h00;
                end else if (calc[i] < floor_duty_reg[i]) begin
                    target[i] = floor_duty_reg[i];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // drives
    // ------------------------------------------------------------------
    logic [7:0] drive1_reg;

    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            drive1_reg <= 8'h00;
        end else begin
            drive1_reg <= target[0];
        end
    end

    assign FAN_DRIVE_1 = drive1_reg;

    fdrf_ramp u_ramp2 (
        .clk       (CORE_CLK),
        .rst       (RST),
        .slot_tick (slot_tick),
        .smooth_en (smooth_enable_drive2),
        .step_sel  (ramp_step_sel_drive2),
        .target    (target[1]),
        .duty      (FAN_DRIVE_2)
    );

    fdrf_ramp u_ramp3 (
        .clk       (CORE_CLK),
        .rst       (RST),
        .slot_tick (slot_tick),
        .smooth_en (smooth_enable_drive3),
        .step_sel  (ramp_step_sel_drive3),
        .target    (target[2]),
        .duty      (FAN_DRIVE_3)
    );

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    property p_floor_locked;
        @(posedge CORE_CLK) disable iff (RST)
        auto_mode |=> (floor_duty_reg[0] == $past(floor_duty_reg[0]) &&
                       floor_duty_reg[1] == $past(floor_duty_reg[1]) &&
                       floor_duty_reg[2] == $past(floor_duty_reg[2]));
    endproperty
    a_floor_locked: assert property (p_floor_locked) else $error("floor written in auto mode");

    property p_floor_write;
        @(posedge CORE_CLK) disable iff (RST)
        (REG_WR && !auto_mode && REG_ADDR == fdrf_pkg::ADDR_FAN2_FLOOR_DUTY) |=> floor_duty_reg[1] == $past(REG_WDATA);
    endproperty
    a_floor_write: assert property (p_floor_write) else $error("floor write lost");

    property p_reset_vals;
        @(posedge CORE_CLK) $past(RST) |-> (ramp_ctrl_reg == 8'h00 && floor_duty_reg[0] == 8'h80);
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("bad reset value");

    property p_below_off;
        @(posedge CORE_CLK) disable iff (RST)
        (auto_mode && BELOW_START[0] && !below_start_keep_floor[0]) |=> FAN_DRIVE_1 == 8'h00;
    endproperty
    a_below_off: assert property (p_below_off) else $error("drive 1 not off below start");

    property p_above_floor;
        @(posedge CORE_CLK) disable iff (RST)
        (auto_mode && !BELOW_START[0]) |=> FAN_DRIVE_1 >= $past(floor_duty_reg[0]);
    endproperty
    a_above_floor: assert property (p_above_floor) else $error("drive 1 below floor");

    sequence s_read_ramp;
        REG_RD && REG_ADDR == fdrf_pkg::ADDR_ACOUSTIC_RAMP_CONTROL;
    endsequence
    property p_read_ramp;
        @(posedge CORE_CLK) disable iff (RST)
        s_read_ramp |=> REG_RDATA == $past(ramp_ctrl_reg);
    endproperty
    a_read_ramp: assert property (p_read_ramp) else $error("ramp control readback wrong");

endmodule

`default_nettype wire

//--- fdrf_fan_model.sv
/*
 * fdrf_fan_model: one fan hung on a duty output; counts the duty changes it sees.
 * assumes: duty is registered on clk and held between updates.
 */
`default_nettype none

module fdrf_fan_model (
    input  wire logic        clk,
    input  wire logic [7:0]  duty,
    output wire logic [15:0] n_change
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [7:0]  last_duty = 8'h00;
    logic [15:0] cnt       = 16'h0000;

    assign n_change = cnt;

    // a fan only feels a duty change, so that is all it reports
    always @(posedge clk) begin
        if (duty !== last_duty) begin
            cnt <= cnt + 16'h0001;
        end
        last_duty <= duty;
    end
endmodule

`default_nettype wire

//--- tb_fdrf_top.sv
/*
 * tb_fdrf_top: self-checking bench for the fan duty ramp and floor block.
 * assumes: fdrf_pkg, fdrf_top and fdrf_fan_model are compiled before it.
 */
`default_nettype none

module tb_fdrf_top;
    timeunit 1ns;
    timeprecision 100ps;

    localparam longint SLOT = 8;

    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic [7:0]  addr  = 8'h00;
    logic [7:0]  wdata = 8'h00;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic [7:0]  rdata;
    logic [7:0]  c1    = 8'h00;
    logic [7:0]  c2    = 8'h00;
    logic [7:0]  c3    = 8'h00;
    logic [2:0]  below = 3'h0;
    logic [7:0]  d1;
    logic [7:0]  d2;
    logic [7:0]  d3;
    logic [15:0] nc2;
    logic [15:0] nc3;
    int          n_fail  = 0;
    int          n_tests = 0;
    logic [7:0]  step_tab [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0c, 8'h18, 8'h30};

    always #2 clk = ~clk;

    fdrf_top #(.SLOT_CYCLES(SLOT)) dut (
        .CORE_CLK(clk), .RST(rst), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
        .REG_RDATA(rdata), .CALC_DUTY_1(c1), .CALC_DUTY_2(c2), .CALC_DUTY_3(c3), .BELOW_START(below),
        .FAN_DRIVE_1(d1), .FAN_DRIVE_2(d2), .FAN_DRIVE_3(d3)
    );
    fdrf_fan_model fan2 (.clk(clk), .duty(d2), .n_change(nc2));
    fdrf_fan_model fan3 (.clk(clk), .duty(d3), .n_change(nc3));

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    task automatic conclude();
        if (n_fail == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic chk_reg(input string what, input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        chk(what, exp, rdata);
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic chk_drives(input logic [7:0] e1, input logic [7:0] e2, input logic [7:0] e3);
        settle();
        chk("drive1", e1, d1);
        chk("drive2", e2, d2);
        chk("drive3", e3, d3);
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        chk_reg("ramp_ctl", fdrf_pkg::ADDR_ACOUSTIC_RAMP_CONTROL, 8'h00);
        chk_reg("floor1", fdrf_pkg::ADDR_FAN1_FLOOR_DUTY, 8'h80);
        chk_reg("floor2", fdrf_pkg::ADDR_FAN2_FLOOR_DUTY, 8'h80);
        chk_reg("floor3", fdrf_pkg::ADDR_FAN3_FLOOR_DUTY, 8'h80);
        chk_reg("unmapped", 8'h70, 8'h00);
    endtask

    // floors at 40h and at both ends of the scale, then automatic mode on them
    task automatic t_auto();
        reg_wr(fdrf_pkg::ADDR_FAN1_FLOOR_DUTY, 8'h40);
        reg_wr(fdrf_pkg::ADDR_FAN2_FLOOR_DUTY, 8'hff);
        reg_wr(fdrf_pkg::ADDR_FAN3_FLOOR_DUTY, 8'h00);
        chk_reg("floor1", fdrf_pkg::ADDR_FAN1_FLOOR_DUTY, 8'h40);
        chk_reg("floor2", fdrf_pkg::ADDR_FAN2_FLOOR_DUTY, 8'hff);
        chk_reg("floor3", fdrf_pkg::ADDR_FAN3_FLOOR_DUTY, 8'h00);
        reg_wr(fdrf_pkg::ADDR_FAN_MODE_CONTROL, 8'h21);
        chk_reg("mode_ctl", fdrf_pkg::ADDR_FAN_MODE_CONTROL, 8'h21);
        reg_wr(fdrf_pkg::ADDR_FAN1_FLOOR_DUTY, 8'h11);
        chk_reg("floor1 locked", fdrf_pkg::ADDR_FAN1_FLOOR_DUTY, 8'h40);
        @(posedge clk);
        below <= 3'h7;
        chk_drives(8'h40, 8'h00, 8'h00);
        reg_wr(fdrf_pkg::ADDR_FAN_MODE_CONTROL, 8'h41);
        chk_drives(8'h00, 8'hff, 8'h00);
        @(posedge clk);
        c1    <= 8'h10;
        c2    <= 8'h90;
        c3    <= 8'h10;
        below <= 3'h0;
        chk_drives(8'h40, 8'hff, 8'h10);
        reg_wr(fdrf_pkg::ADDR_FAN_MODE_CONTROL, 8'h00);
        chk_drives(8'h10, 8'h90, 8'h10);
    endtask

    // 33% to full on one drive; the other drive, not smoothed, jumps
    task automatic t_ramp(input int drv, input logic [2:0] code);
        logic [7:0]  step;
        logic [7:0]  prev;
        logic [7:0]  cur;
        logic [15:0] n0;
        int          k;
        step = step_tab[code];
        reg_wr(fdrf_pkg::ADDR_ACOUSTIC_RAMP_CONTROL, 8'h00);
        c2 <= 8'h54;
        c3 <= 8'h54;
        chk_drives(8'h10, 8'h54, 8'h54);
        n0 = (drv == 3) ? nc3 : nc2;
        reg_wr(fdrf_pkg::ADDR_ACOUSTIC_RAMP_CONTROL, (drv == 3) ? {5'h01, code} : {1'b1, code, 4'h0});
        c2 <= 8'hff;
        c3 <= 8'hff;
        prev = 8'h54;
        for (k = 0; k < 3000 && prev !== 8'hff; k++) begin
            @(posedge clk);
            #1;
            cur = (drv == 3) ? d3 : d2;
            if (cur !== prev) begin
                chk("ramp step", (8'hff - prev < step) ? 8'hff : prev + step, cur);
                prev = cur;
            end
            if (k == 2) begin
                chk("unsmoothed drive", 8'hff, (drv == 3) ? d2 : d3);
            end
        end
        if (prev !== 8'hff) begin
            n_fail++;
            conclude();
        end
        // the fan sees the last step one edge after the bench does
        @(posedge clk);
        #1;
        chk("ramp slots", 8'((171 + step - 1) / step), 8'(((drv == 3) ? nc3 : nc2) - n0));
    endtask

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_auto();
        for (int c = 0; c < 8; c++) begin
            t_ramp(3, 3'(c));
            t_ramp(2, 3'(c));
        end
        conclude();
    end
endmodule

`default_nettype wire
